// ### sdmc_pkg.sv
package sdmc_pkg;

  localparam int unsigned CFG_W          = 13;
  localparam int unsigned PIPE_W         = 16;

  // Configuration register selection on the bank lines.
  localparam logic [1:0]  BANK_MODE      = 2'h0;
  localparam logic [1:0]  BANK_EXT       = 2'h1;

  // Main configuration register layout.
  localparam int unsigned BURST_LSB      = 0;
  localparam int unsigned ORDER_BIT      = 3;
  localparam int unsigned READ_DLY_LSB   = 4;
  localparam int unsigned TEST_BIT       = 7;
  localparam int unsigned LOOP_RST_BIT   = 8;
  localparam int unsigned POST_WR_LSB    = 9;
  localparam int unsigned PD_EXIT_BIT    = 12;

  // Extended configuration register layout.
  localparam int unsigned LOOP_EN_BIT    = 0;
  localparam int unsigned ADD_LAT_LSB    = 3;
  localparam int unsigned DRV_CAL_LSB    = 7;

  localparam logic        LOOP_ON_VALUE  = 1'b0;
  localparam logic        ORDER_SEQ      = 1'b0;
  localparam logic        ORDER_ILV      = 1'b1;
  localparam logic [2:0]  BURST_ENC_4    = 3'h2;
  localparam logic [2:0]  BURST_ENC_8    = 3'h3;
  localparam logic [2:0]  READ_DLY_MIN   = 3'h3;
  localparam logic [2:0]  READ_DLY_MAX   = 3'h7;
  localparam logic [2:0]  POST_WR_MINENC = 3'h1;
  localparam logic [2:0]  ADD_LAT_MAX    = 3'h6;
  localparam logic [2:0]  DRV_CAL_DFLT   = 3'h7;

  // Burst of four, sequential, read delay 3, post-write delay 2.
  localparam logic [12:0] MODE_RESET     = 13'h0232;
  // Loop enabled, added latency 0, calibration bits clear.
  localparam logic [12:0] EXT_RESET      = 13'h0000;

  localparam int unsigned LOCK_CYCLES    = 200;
  localparam logic [7:0]  LOCK_CNT_LAST  = 8'(LOCK_CYCLES - 1);

endpackage

// ### sdmc_burst_order.sv
`timescale 1ns/1ps
module sdmc_burst_order (
  input  wire logic [2:0] start_i,
  input  wire logic [2:0] beat_i,
  input  wire logic       bl8_i,
  input  wire logic       ilv_i,
  output logic      [2:0] col_o
);
  logic [1:0] low_seq;
  logic [1:0] low_ilv;

  // Sequential order wraps inside a group of four, so the eight-beat form is nibble based.
  assign low_seq = start_i[1:0] + beat_i[1:0]; // RULE_04
  assign low_ilv = start_i[1:0] ^ beat_i[1:0]; // RULE_05
  assign col_o   = {start_i[2] ^ (bl8_i & beat_i[2]), ilv_i ? low_ilv : low_seq}; // RULE_03
endmodule

// ### sdmc_mode_decode.sv
`timescale 1ns/1ps
// Function
// (RULE_01) One bit picks burst column ordering.
// (RULE_02) Zero sequential, one interleaved.
// (RULE_03) Bursts of four or eight; order from address.
// (RULE_04) Eight-beat sequential wraps within each half.
// (RULE_05) Interleaved offset is start XOR beat.
// (RULE_06) Test bit set: program nothing else.
// (RULE_07) Loop reset bit pulses reset, self-clears.
// (RULE_08) Controller waits 200 clocks before reads.
// (RULE_09) Post-write delay field: 2 to 8 clocks.
// (RULE_10) Auto precharge follows last data by delay.
// (RULE_11) Controller rounds recovery time up to clocks.
// (RULE_12) Bit zero: fast wake, loop keeps running.
// (RULE_13) Bit one: slow wake, loop frozen.
// (RULE_14) Read delay field: 3 to 7 clocks.
// (RULE_15) Read data at edge n plus delay.
// (RULE_16) Read held added latency; total sums both.
// (RULE_17) Controller loads config only when idle.
// (RULE_18) Configuration holds until reloaded.
// (RULE_19) Bits above 12 written as zero.
// (RULE_20) Calibration bits all one, then zero.
// (RULE_21) One bit enables loop; enable then reset.
// (RULE_22) Self refresh disables loop, exit resets it.
// (RULE_23) Slow clock, loop off: precharge after refresh.
// (RULE_24) Burst size field selects four or eight.
// (RULE_25) Write latency is read latency minus one.
// (RULE_26) Added latency field gives 0 to 6.
module sdmc_mode_decode (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       cfg_load_i,
  input  wire logic [1:0]                 cfg_bank_i,
  input  wire logic                       cfg_third_bank_i,
  input  wire logic [sdmc_pkg::CFG_W-1:0] cfg_addr_i,
  input  wire logic                       rd_cmd_i,
  input  wire logic [2:0]                 rd_col_i,
  input  wire logic                       wr_cmd_i,
  input  wire logic [2:0]                 wr_col_i,
  input  wire logic                       wr_ap_i,
  input  wire logic                       apd_enter_i,
  input  wire logic                       ppd_enter_i,
  input  wire logic                       pd_exit_i,
  input  wire logic                       sr_enter_i,
  input  wire logic                       sr_exit_i,
  output logic [sdmc_pkg::CFG_W-1:0]      mode_reg_o,
  output logic [sdmc_pkg::CFG_W-1:0]      ext_reg_o,
  output logic                            test_mode_o,
  output logic                            cfg_error_o,
  output logic                            drv_cal_default_o,
  output logic                            loop_reset_o,
  output logic                            loop_run_o,
  output logic                            loop_locked_o,
  output logic                            early_read_o,
  output logic                            apd_active_o,
  output logic                            ppd_active_o,
  output logic                            slow_wake_o,
  output logic                            self_refresh_o,
  output logic                            rd_data_start_o,
  output logic                            wr_data_start_o,
  output logic                            burst_active_o,
  output logic [2:0]                      beat_col_rise_o,
  output logic [2:0]                      beat_col_fall_o,
  output logic                            precharge_start_o
);
  import sdmc_pkg::*;

  typedef struct packed {
    logic [CFG_W-1:0]  mode;
    logic [CFG_W-1:0]  ext;
    logic              test_mode;
    logic              cfg_err;
    logic              loop_rst;
    logic [7:0]        lock_cnt;
    logic              locking;
    logic              locked;
    logic              early_rd;
    logic              in_sr;
    logic              in_apd;
    logic              in_ppd;
    logic [PIPE_W-1:0] rd_pipe;
    logic [PIPE_W-1:0] wr_pipe;
    logic [2:0]        rd_col;
    logic [2:0]        wr_col;
    logic              wr_ap;
    logic              rd_start;
    logic              wr_start;
    logic              burst_on;
    logic [1:0]        pair_idx;
    logic [2:0]        burst_col;
    logic [2:0]        col_rise;
    logic [2:0]        col_fall;
    logic [4:0]        pre_cnt;
    logic              pre_busy;
    logic              pre_start;
    logic              cal_dflt;
    logic              run_loop;
    logic              wake_slow;
  } sdmc_state_t;

  sdmc_state_t s_q;
  sdmc_state_t s_d;

  logic       bl8;
  logic       ilv;
  logic [2:0] read_dly;
  logic [2:0] add_lat;
  logic [3:0] post_wr;
  logic [3:0] rl;
  logic [3:0] wl;
  logic [1:0] pair_last;
  logic [2:0] beat_rise;
  logic [2:0] beat_fall;
  logic [2:0] next_rise;
  logic [2:0] next_fall;
  logic [2:0] next_start;
  logic       loop_on;

  assign bl8       = s_q.mode[BURST_LSB +: 3] == BURST_ENC_8; // RULE_24
  assign ilv       = s_q.mode[ORDER_BIT] == ORDER_ILV; // RULE_01 RULE_02
  assign read_dly  = s_q.mode[READ_DLY_LSB +: 3]; // RULE_14
  assign add_lat   = s_q.ext[ADD_LAT_LSB +: 3]; // RULE_26
  assign post_wr   = {1'b0, s_q.mode[POST_WR_LSB +: 3]} + 4'h1; // RULE_09
  assign rl        = {1'b0, add_lat} + {1'b0, read_dly}; // RULE_16
  assign wl        = rl - 4'h1; // RULE_25
  assign pair_last = bl8 ? 2'h3 : 2'h1;
  assign loop_on   = s_q.ext[LOOP_EN_BIT] == LOOP_ON_VALUE; // RULE_21
  assign next_start = s_q.rd_start ? s_q.rd_col : s_q.wr_col;
  assign beat_rise = s_q.burst_on ? {s_q.pair_idx, 1'b0} + 3'h2 : 3'h0;
  assign beat_fall = beat_rise + 3'h1;

  sdmc_burst_order u_order_rise (
    .start_i (s_q.burst_on ? s_q.burst_col : next_start),
    .beat_i  (beat_rise),
    .bl8_i   (bl8),
    .ilv_i   (ilv),
    .col_o   (next_rise)
  );

  sdmc_burst_order u_order_fall (
    .start_i (s_q.burst_on ? s_q.burst_col : next_start),
    .beat_i  (beat_fall),
    .bl8_i   (bl8),
    .ilv_i   (ilv),
    .col_o   (next_fall)
  );

  always_comb begin
    s_d = s_q;
    s_d.loop_rst  = 1'b0;
    s_d.pre_start = 1'b0;
    s_d.early_rd  = 1'b0;
    // The stored reset bit is one for a single cycle only, matching the pulse.
    s_d.mode[LOOP_RST_BIT] = 1'b0; // RULE_07

    if (cfg_load_i && cfg_bank_i == BANK_MODE) begin
      s_d.test_mode = cfg_addr_i[TEST_BIT];
      if (!cfg_addr_i[TEST_BIT]) begin // RULE_06
        s_d.mode     = cfg_addr_i; // RULE_18
        s_d.loop_rst = cfg_addr_i[LOOP_RST_BIT]; // RULE_07
        s_d.cfg_err  = cfg_third_bank_i
                     || (cfg_addr_i[BURST_LSB +: 3] != BURST_ENC_4
                         && cfg_addr_i[BURST_LSB +: 3] != BURST_ENC_8) // RULE_03
                     || cfg_addr_i[READ_DLY_LSB +: 3] < READ_DLY_MIN // RULE_14
                     || cfg_addr_i[POST_WR_LSB +: 3] < POST_WR_MINENC; // RULE_09
      end
    end else if (cfg_load_i && cfg_bank_i == BANK_EXT) begin
      s_d.ext     = cfg_addr_i; // RULE_18
      s_d.cfg_err = cfg_third_bank_i // RULE_19
                  || cfg_addr_i[ADD_LAT_LSB +: 3] > ADD_LAT_MAX; // RULE_26
    end

    // Self refresh stops the loop; exit restarts it with a fresh reset.
    if (sr_enter_i) begin
      s_d.in_sr  = 1'b1; // RULE_22
      s_d.in_apd = 1'b0;
      s_d.in_ppd = 1'b0;
    end else if (sr_exit_i && s_q.in_sr) begin
      s_d.in_sr    = 1'b0;
      s_d.loop_rst = 1'b1; // RULE_22
    end

    if (apd_enter_i) begin
      s_d.in_apd = 1'b1; // RULE_12 RULE_13
    end else if (ppd_enter_i) begin
      s_d.in_ppd = 1'b1; // RULE_13
    end else if (pd_exit_i) begin
      s_d.in_apd = 1'b0;
      s_d.in_ppd = 1'b0;
    end

    // Lock tracking shows the controller when reads are safe again.
    if (!loop_on || s_q.in_sr) begin
      s_d.locked  = 1'b0;
      s_d.locking = 1'b0;
    end else if (s_q.loop_rst) begin
      s_d.locked   = 1'b0;
      s_d.locking  = 1'b1;
      s_d.lock_cnt = 8'h00;
    end else if (s_q.locking) begin
      if (s_q.lock_cnt == LOCK_CNT_LAST) begin
        s_d.locking = 1'b0;
        s_d.locked  = 1'b1; // RULE_08
      end else begin
        s_d.lock_cnt = s_q.lock_cnt + 8'h01;
      end
    end
    s_d.early_rd = rd_cmd_i && !s_q.locked; // RULE_08

    // One-hot delay lines; a command injected at bit latency-1 leaves bit 0 then.
    s_d.rd_pipe = s_q.rd_pipe >> 1;
    s_d.wr_pipe = s_q.wr_pipe >> 1;
    if (rd_cmd_i) begin
      s_d.rd_pipe = s_d.rd_pipe | (PIPE_W'(1) << (rl - 4'h1)); // RULE_15 RULE_16
      s_d.rd_col  = rd_col_i;
    end
    if (wr_cmd_i) begin
      s_d.wr_pipe = s_d.wr_pipe | (PIPE_W'(1) << (wl - 4'h1)); // RULE_25
      s_d.wr_col  = wr_col_i;
      s_d.wr_ap   = wr_ap_i;
    end
    s_d.rd_start = s_q.rd_pipe[0]; // RULE_15
    s_d.wr_start = s_q.wr_pipe[0]; // RULE_25

    // Two beats per clock, rising then falling edge.
    if (s_q.rd_start || s_q.wr_start) begin
      s_d.burst_on  = 1'b1;
      s_d.burst_col = next_start;
      s_d.pair_idx  = 2'h0;
      s_d.col_rise  = next_start;
      s_d.col_fall  = next_start;
      s_d.col_fall  = {next_start[2], ilv ? next_start[1:0] ^ 2'h1
                                          : next_start[1:0] + 2'h1}; // RULE_04 RULE_05
    end else if (s_q.burst_on) begin
      if (s_q.pair_idx == pair_last) begin
        s_d.burst_on = 1'b0;
      end else begin
        s_d.pair_idx = s_q.pair_idx + 2'h1;
        s_d.col_rise = next_rise; // RULE_03
        s_d.col_fall = next_fall;
      end
    end

    // Precharge lands post-write delay clocks after the last data pair.
    if (s_q.wr_start && s_q.wr_ap) begin
      s_d.pre_busy = 1'b1;
      s_d.pre_cnt  = {3'h0, pair_last} + {1'b0, post_wr} - 5'h1; // RULE_10
    end else if (s_q.pre_busy) begin
      if (s_q.pre_cnt == 5'h00) begin
        s_d.pre_busy  = 1'b0;
        s_d.pre_start = 1'b1; // RULE_10
      end else begin
        s_d.pre_cnt = s_q.pre_cnt - 5'h01;
      end
    end

    // Decodes are taken from the next state so every output leaves a flop on time.
    s_d.cal_dflt  = s_d.ext[DRV_CAL_LSB +: 3] == DRV_CAL_DFLT; // RULE_20
    s_d.wake_slow = s_d.in_apd && s_d.mode[PD_EXIT_BIT]; // RULE_13
    // Slow exit freezes the loop; precharge power-down never does.
    s_d.run_loop  = s_d.ext[LOOP_EN_BIT] == LOOP_ON_VALUE && !s_d.in_sr
                    && !s_d.wake_slow; // RULE_12 RULE_13
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q          <= '0;
      s_q.mode     <= MODE_RESET;
      s_q.ext      <= EXT_RESET;
      // The reset extended value has the loop enabled, so it runs from the start.
      s_q.run_loop <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign mode_reg_o        = s_q.mode;
  assign ext_reg_o         = s_q.ext;
  assign test_mode_o       = s_q.test_mode;
  assign cfg_error_o       = s_q.cfg_err;
  assign drv_cal_default_o = s_q.cal_dflt; // RULE_20
  assign loop_reset_o      = s_q.loop_rst;
  assign loop_run_o        = s_q.run_loop; // RULE_12 RULE_13
  assign loop_locked_o     = s_q.locked;
  assign early_read_o      = s_q.early_rd;
  assign apd_active_o      = s_q.in_apd;
  assign ppd_active_o      = s_q.in_ppd;
  assign slow_wake_o       = s_q.wake_slow; // RULE_13
  assign self_refresh_o    = s_q.in_sr;
  assign rd_data_start_o   = s_q.rd_start;
  assign wr_data_start_o   = s_q.wr_start;
  assign burst_active_o    = s_q.burst_on;
  assign beat_col_rise_o   = s_q.col_rise;
  assign beat_col_fall_o   = s_q.col_fall;
  assign precharge_start_o = s_q.pre_start;
endmodule

// ### sdmc_chk.sv
`timescale 1ns/1ps
module sdmc_chk (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        cfg_load_i,
  input wire logic [1:0]  cfg_bank_i,
  input wire logic [12:0] cfg_addr_i,
  input wire logic        rd_cmd_i,
  input wire logic        wr_cmd_i,
  input wire logic        wr_ap_i,
  input wire logic        sr_enter_i,
  input wire logic [12:0] mode_reg_o,
  input wire logic [12:0] ext_reg_o,
  input wire logic        test_mode_o,
  input wire logic        loop_reset_o,
  input wire logic        loop_run_o,
  input wire logic        self_refresh_o,
  input wire logic        slow_wake_o,
  input wire logic        apd_active_o,
  input wire logic        rd_data_start_o,
  input wire logic        wr_data_start_o,
  input wire logic        burst_active_o,
  input wire logic        precharge_start_o
);
  import sdmc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic main_ld;
  logic base_cfg;
  assign main_ld = cfg_load_i && cfg_bank_i == BANK_MODE;
  // Latency figures below hold only for read delay 3 and no added latency.
  assign base_cfg = mode_reg_o[6:4] == 3'h3 && ext_reg_o[5:3] == 3'h0;
  chk_loop_rst_pulse: assert property (main_ld && cfg_addr_i[8] && !cfg_addr_i[7] |->
    ##1 (loop_reset_o && mode_reg_o[8]) ##1 !(loop_reset_o || mode_reg_o[8]))
    else $error("loop reset pulse wrong");
  chk_test_mode_hold: assert property (main_ld && cfg_addr_i[7] |->
    ##2 (test_mode_o && mode_reg_o == $past(mode_reg_o, 2))) else $error("test load altered");
  chk_read_lat: assert property (rd_cmd_i && base_cfg |-> ##4 rd_data_start_o)
    else $error("read start late");
  chk_write_lat: assert property (wr_cmd_i && base_cfg |-> ##3 wr_data_start_o)
    else $error("write start late");
  chk_burst_eight: assert property (rd_data_start_o && mode_reg_o[2:0] == BURST_ENC_8 |=>
    burst_active_o [*4] ##1 !burst_active_o) else $error("burst length wrong");
  chk_auto_pre: assert property (wr_cmd_i && wr_ap_i && base_cfg &&
    mode_reg_o[11:9] == 3'h1 && mode_reg_o[2:0] == BURST_ENC_4 |-> ##7 precharge_start_o)
    else $error("precharge timing wrong");
  chk_wake_style: assert property ($rose(apd_active_o) |-> slow_wake_o == mode_reg_o[12])
    else $error("wake style wrong");
  chk_sr_loop_off: assert property (sr_enter_i |-> ##[1:2] (self_refresh_o && !loop_run_o))
    else $error("loop not stopped");
endmodule

bind sdmc_mode_decode sdmc_chk sdmc_chk_i (.clk_i, .rst_n_i, .cfg_load_i, .cfg_bank_i,
  .cfg_addr_i, .rd_cmd_i, .wr_cmd_i, .wr_ap_i, .sr_enter_i, .mode_reg_o, .ext_reg_o,
  .test_mode_o, .loop_reset_o, .loop_run_o, .self_refresh_o, .slow_wake_o, .apd_active_o,
  .rd_data_start_o, .wr_data_start_o, .burst_active_o, .precharge_start_o);

// ### sdmc_ctrl_model.sv
`timescale 1ns/1ps
module sdmc_ctrl_model (
  input  wire logic  clk_i,
  output logic       cfg_load_o,
  output logic [1:0] cfg_bank_o,
  output logic       cfg_third_bank_o,
  output logic [12:0] cfg_addr_o,
  output logic [2:0] col_o,
  output logic       wr_ap_o,
  output logic [6:0] pulse_o
);
  initial begin
    cfg_load_o = 1'b0;
    cfg_bank_o = 2'h3;
    cfg_third_bank_o = 1'b0;
    cfg_addr_o = 13'h0000;
    col_o = 3'h0;
    wr_ap_o = 1'b0;
    pulse_o = 7'h00;
  end
  // The clock stays at 25 MHz with the loop on, so no precharge-all is owed.
  // Released lines are inverted so a stale value can never look valid.
  task automatic load(input logic [1:0] bank, input logic [12:0] value);
    @(negedge clk_i);
    cfg_load_o = 1'b1;
    cfg_bank_o = bank;
    cfg_addr_o = value;
    @(negedge clk_i);
    cfg_load_o = 1'b0;
    cfg_bank_o = ~bank;
    cfg_addr_o = ~value;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic cmd(input int unsigned idx, input logic [2:0] col, input logic ap);
    @(negedge clk_i);
    pulse_o[idx] = 1'b1;
    col_o = col;
    wr_ap_o = ap;
    @(negedge clk_i);
    pulse_o = 7'h00;
    col_o = ~col;
    wr_ap_o = ~ap;
  endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`define CHK(nm, got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("BAD %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module testbench;
  import sdmc_pkg::*;
  typedef struct packed {
    logic        bl8;
    logic        ilv;
    logic [11:0] st_cl_al_wr;
    logic [23:0] cols;
  } sdmc_row_t;
  logic        clk_i, rst_n_i, cfg_load_i, cfg_third_bank_i, wr_ap_i, rd_cmd_i, wr_cmd_i;
  logic        apd_enter_i, ppd_enter_i, pd_exit_i, sr_enter_i, sr_exit_i, test_mode_o;
  logic        cfg_error_o, loop_reset_o, loop_run_o, loop_locked_o, apd_active_o;
  logic        ppd_active_o, slow_wake_o, self_refresh_o, rd_data_start_o, wr_data_start_o;
  logic        burst_active_o, precharge_start_o, drv_cal_default_o, early_read_o;
  logic [1:0]  cfg_bank_i;
  logic [2:0]  col, beat_col_rise_o, beat_col_fall_o, st, cl, al, wr;
  logic [6:0]  pulse;
  logic [12:0] cfg_addr_i, mode_reg_o, ext_reg_o;
  int          failures, tests_run, n, rl, bw;
  sdmc_row_t   rows [6] = '{'{0, 0, 12'h2c1, 24'h298000}, '{0, 1, 12'h713, 24'h688000},
                           '{1, 0, 12'hb4a, 24'hbbc298}, '{1, 1, 12'h7a5, 24'h688fac},
                           '{1, 0, 12'hff7, 24'hf2e60a}, '{0, 1, 12'h2dc, 24'h21a000}};
  logic [12:0] bad [3] = '{13'h0222, 13'h0032, 13'h0232};
  assign {sr_exit_i, sr_enter_i, pd_exit_i, ppd_enter_i, apd_enter_i, wr_cmd_i, rd_cmd_i} = pulse;
  sdmc_ctrl_model sdmc_ctrl_model_i (.clk_i, .cfg_load_o(cfg_load_i), .cfg_bank_o(cfg_bank_i),
    .cfg_third_bank_o(cfg_third_bank_i), .cfg_addr_o(cfg_addr_i), .col_o(col),
    .wr_ap_o(wr_ap_i), .pulse_o(pulse));
  sdmc_mode_decode sdmc_mode_decode_i (.clk_i, .rst_n_i, .cfg_load_i, .cfg_bank_i,
    .cfg_third_bank_i, .cfg_addr_i, .rd_cmd_i, .rd_col_i(col), .wr_cmd_i, .wr_col_i(col),
    .wr_ap_i, .apd_enter_i, .ppd_enter_i, .pd_exit_i, .sr_enter_i, .sr_exit_i, .mode_reg_o,
    .ext_reg_o, .test_mode_o, .cfg_error_o, .drv_cal_default_o, .loop_reset_o, .loop_run_o,
    .loop_locked_o, .early_read_o, .apd_active_o, .ppd_active_o, .slow_wake_o,
    .self_refresh_o, .rd_data_start_o, .wr_data_start_o, .burst_active_o, .beat_col_rise_o,
    .beat_col_fall_o, .precharge_start_o);
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wait_for(input int unsigned sel, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (hit !== 1'b1) begin
      @(negedge clk_i);
      cnt++;
      hit = (sel == 0) ? rd_data_start_o : (sel == 1) ? wr_data_start_o : precharge_start_o;
      if (cnt > 40) begin
        failures++;
        print_verdict();
      end
    end
  endtask
  task automatic step(input int unsigned idx);
    sdmc_ctrl_model_i.cmd(idx, 3'h0, 1'b0);
    @(negedge clk_i);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    failures = 0;
    tests_run = 0;
    rst_n_i = 1'b0;
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    `CHK("mode reset", mode_reg_o, MODE_RESET)
    `CHK("loop on", loop_run_o, 1'b1)
    sdmc_ctrl_model_i.load(BANK_EXT, {3'h0, DRV_CAL_DFLT, 7'h00});
    `CHK("cal default", drv_cal_default_o, 1'b1)
    sdmc_ctrl_model_i.load(BANK_EXT, EXT_RESET);
    `CHK("cal cleared", drv_cal_default_o, 1'b0)
    sdmc_ctrl_model_i.load(BANK_MODE, MODE_RESET | 13'h0100);
    repeat (198) @(negedge clk_i);
    `CHK("lock early", loop_locked_o, 1'b0)
    repeat (4) @(negedge clk_i);
    `CHK("lock", loop_locked_o, 1'b1)
    foreach (rows[i]) begin
      {st, cl, al, wr} = rows[i].st_cl_al_wr;
      bw = rows[i].bl8 ? 4 : 2;
      sdmc_ctrl_model_i.load(BANK_EXT, {7'h00, al, 3'h0});
      sdmc_ctrl_model_i.load(BANK_MODE, {1'b0, wr, 2'h0, cl, rows[i].ilv,
        (rows[i].bl8 ? BURST_ENC_8 : BURST_ENC_4)});
      rl = cl + al;
      sdmc_ctrl_model_i.cmd(0, st, 1'b0);
      `CHK("locked read", early_read_o, 1'b0)
      wait_for(0, n);
      `CHK("read latency", n, rl)
      for (int k = 0; k < bw; k++) begin
        @(negedge clk_i);
        `CHK("rise col", beat_col_rise_o, rows[i].cols[23-6*k -: 3])
        `CHK("fall col", beat_col_fall_o, rows[i].cols[20-6*k -: 3])
      end
      sdmc_ctrl_model_i.cmd(1, st, 1'b1);
      wait_for(1, n);
      `CHK("write latency", n, rl - 1)
      wait_for(2, n);
      `CHK("precharge delay", n, bw + wr + 1)
    end
    foreach (bad[i]) begin
      sdmc_ctrl_model_i.load(BANK_MODE, bad[i]);
      `CHK("reserved flag", cfg_error_o, i < 2)
    end
    sdmc_ctrl_model_i.load(BANK_MODE, 13'h0080);
    `CHK("test keeps", mode_reg_o, MODE_RESET)
    `CHK("test flag", test_mode_o, 1'b1)
    sdmc_ctrl_model_i.load(BANK_MODE, 13'h1232);
    step(2);
    `CHK("slow wake", slow_wake_o, 1'b1)
    step(4);
    step(3);
    `CHK("ppd wake", {ppd_active_o, slow_wake_o}, 2'h2)
    step(4);
    sdmc_ctrl_model_i.load(BANK_MODE, MODE_RESET);
    step(2);
    `CHK("fast wake", {slow_wake_o, loop_run_o}, 2'h1)
    step(4);
    step(5);
    `CHK("sr loop off", loop_run_o, 1'b0)
    step(6);
    @(negedge clk_i);
    `CHK("sr relock", {loop_run_o, loop_locked_o}, 2'h2)
    sdmc_ctrl_model_i.cmd(0, 3'h0, 1'b0);
    `CHK("early read", early_read_o, 1'b1)
    print_verdict();
  end
endmodule
